// ---- rtl/osc_consts.svh ----
// Register offsets, field positions, reset values and timing figures.
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH
`define ADR_SYS_CLK_CTRL 8'h00
`define ADR_FAST_RC_CTRL 8'h04
`define ADR_FAST_XT_CTRL 8'h08
`define ADR_SLOW_XT_CTRL 8'h0c
`define ADR_SW_STATUS 8'h10
`define ADR_PIN_SHARE 8'h14
`define DIV_HI 7
`define DIV_LO 5
`define HSEL_BIT 3
`define LSEL_BIT 2
`define FIDLE_BIT 1
`define SIDLE_BIT 0
`define FREQ_HI 3
`define FREQ_LO 2
`define SPEEDUP_BIT 2
`define STABLE_BIT 1
`define EN_BIT 0
`define BUSY_BIT 2
`define DIV_SLOW 3'h7
`define RST_DIV 3'h0
`define RST_FREQ 2'h0
`define RST_FRC_EN 1'h1
`define RST_SPEEDUP 1'h1
`define SRC_FAST_RC 2'h0
`define SRC_FAST_XT 2'h1
`define SRC_SLOW_XT 2'h2
`define SRC_SLOW_RC 2'h3
`define CLK_MHZ 25
`define FAST_RC_START_US 16
`define SLOW_RC_START_US 100
`define FAST_XT_START_US 1000
`define SLOW_XT_SP_START_US 100000
`define SLOW_XT_LP_START_US 1000000
`endif

// ---- rtl/osc_pkg.sv ----
// Types shared by the oscillator source selection modules.
package osc_pkg;
  typedef logic [1:0] src_t;
  typedef enum logic [2:0] {
    SW_RUN = 3'h1,
    SW_STOP = 3'h2,
    SW_MOVE = 3'h4
  } sw_state_e;
  typedef struct packed {
    sw_state_e state;
    src_t active;
    logic gate;
  } sw_s;
  typedef struct packed {
    logic [2:0] div;
    logic hsel;
    logic lsel;
    logic fidle;
    logic sidle;
    logic [1:0] frc_freq;
    logic frc_en;
    logic fxt_en;
    logic sxt_en;
    logic sxt_sp;
    logic pin_osc;
    logic ack;
    logic [7:0] rdata;
  } regs_s;
endpackage : osc_pkg

// ---- rtl/osc_sw_if.sv ----
// Request and status signals between the selector and the clock switch.
`timescale 1ns/1ps
interface osc_sw_if;
  osc_pkg::src_t req_src;
  logic req_ok;
  osc_pkg::src_t active;
  logic gate;
  logic busy;
  modport main (output req_src, output req_ok, input active, input gate,
    input busy);
  modport sw (input req_src, input req_ok, output active, output gate,
    output busy);
endinterface : osc_sw_if

// ---- rtl/osc_startup_timer.sv ----
// Start-up delay counter that raises a stable flag for one oscillator.
`timescale 1ns/1ps
module osc_startup_timer #(
  parameter int unsigned W = 25
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic en_i, // Oscillator enable.
  input wire logic [W-1:0] target_i, // Start-up delay in cycles.
  output logic stable_o // Oscillator usable.
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic stable;
  } tmr_s;
  tmr_s s_reg, s_next;

  // Once stable the flag holds while enabled, so a longer target that
  // appears later (mode change) cannot pull a running clock away.
  always_comb begin
    s_next = s_reg;
    if (!en_i) begin
      s_next = '0;
    end else if (!s_reg.stable) begin
      if (s_reg.cnt >= target_i) begin
        s_next.stable = 1'h1;
      end else begin
        s_next.cnt = s_reg.cnt + W'(1);
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign stable_o = s_reg.stable;
endmodule : osc_startup_timer

// ---- rtl/osc_clk_switch.sv ----
// Glitch-free hand-over of the system clock between oscillators.
`timescale 1ns/1ps
`include "osc_consts.svh"
module osc_clk_switch (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  osc_sw_if.sw sw // Request from and status to the selector.
);
  osc_pkg::sw_s s_reg, s_next;

  // The gate is closed for a full cycle on each side of the source
  // change, so no shortened pulse can reach the clock tree.
  always_comb begin
    s_next = s_reg;
    unique case (s_reg.state)
      osc_pkg::SW_RUN: begin
        if (sw.req_src != s_reg.active && sw.req_ok) begin
          s_next.gate = 1'h0;
          s_next.state = osc_pkg::SW_STOP;
        end
      end
      osc_pkg::SW_STOP: begin
        if (sw.req_ok) begin
          s_next.active = sw.req_src;
          s_next.state = osc_pkg::SW_MOVE;
        end
      end
      osc_pkg::SW_MOVE: begin
        s_next.gate = 1'h1;
        s_next.state = osc_pkg::SW_RUN;
      end
      default: begin
        s_next.gate = 1'h0;
        s_next.state = osc_pkg::SW_STOP;
      end
    endcase
  end

  // State register; the clock stays gated until the first source settles.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg.state <= osc_pkg::SW_STOP;
      s_reg.active <= `SRC_FAST_RC;
      s_reg.gate <= 1'h0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sw.active = s_reg.active;
  assign sw.gate = s_reg.gate;
  assign sw.busy = (s_reg.state != osc_pkg::SW_RUN);
endmodule : osc_clk_switch

// ---- rtl/osc_source_select.sv ----
// Oscillator enables, start-up tracking and system clock source selection.
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "osc_consts.svh"
module osc_source_select #(
  parameter int unsigned CNT_W = 25,
  parameter int unsigned FAST_XT_START_CYC = `FAST_XT_START_US * `CLK_MHZ,
  parameter int unsigned SLOW_XT_SP_START_CYC =
    `SLOW_XT_SP_START_US * `CLK_MHZ,
  parameter int unsigned SLOW_XT_LP_START_CYC =
    `SLOW_XT_LP_START_US * `CLK_MHZ
) (
  input wire logic clk_i, // System clock, 25 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic halt_i, // CPU halted (sleep or idle).
  output logic [3:0] osc_en_o, // One enable per oscillator.
  output logic [1:0] fast_rc_freq_o, // Fast RC frequency code.
  output logic slow_crystal_speedup_o, // Slow crystal speed-up mode.
  output logic slow_crystal_pins_osc_o, // Crystal pins used by oscillator.
  output logic [1:0] sys_src_o, // Source now driving the system clock.
  output logic sys_clk_gate_o, // System clock allowed to run.
  output logic [2:0] clk_div_sel_o, // System clock divider select.
  output logic fast_periph_en_o, // Fast clock kept for peripherals.
  output logic sub_clk_en_o // Slow clock kept for peripherals.
);
  localparam int unsigned FAST_RC_START_CYC = `FAST_RC_START_US * `CLK_MHZ;
  localparam int unsigned SLOW_RC_START_CYC = `SLOW_RC_START_US * `CLK_MHZ;

  osc_pkg::regs_s r_reg, r_next;
  osc_pkg::src_t req_src;
  logic [3:0] stable;
  logic [3:0][CNT_W-1:0] target;
  logic sxt_locked;
  logic wb_req;
  logic wb_wr;
  logic [7:0] word_adr;
  logic [7:0] rd_mux;

  osc_sw_if sw_if ();

  //////////////////////////////////////////////////////////////////////
  // Source request and oscillator enables.

  // Divider code 7 takes the slow source; every other code a divided
  // fast source, the division itself done by the downstream divider.
  always_comb begin
    if (r_reg.div == `DIV_SLOW) begin
      req_src = r_reg.lsel ? `SRC_SLOW_XT : `SRC_SLOW_RC;
    end else begin
      req_src = r_reg.hsel ? `SRC_FAST_XT : `SRC_FAST_RC;
    end
  end

  assign sw_if.req_src = req_src;
  assign sw_if.req_ok = stable[req_src];

  // The active source is held on even if software drops its enable,
  // since stopping it would freeze the system clock.
  assign osc_en_o[0] = r_reg.frc_en | (sw_if.active == `SRC_FAST_RC);
  assign osc_en_o[1] = r_reg.fxt_en | (sw_if.active == `SRC_FAST_XT);
  assign osc_en_o[2] = r_reg.sxt_en |
                       (sw_if.active == `SRC_SLOW_XT);
  // The slow RC never stops, so timers have a clock during halt.
  assign osc_en_o[3] = 1'h1;

  // Start-up delays; the slow crystal waits longer in low power mode.
  assign target[0] = CNT_W'(FAST_RC_START_CYC);
  assign target[1] = CNT_W'(FAST_XT_START_CYC);
  assign target[2] = r_reg.sxt_sp ? CNT_W'(SLOW_XT_SP_START_CYC)
                                  : CNT_W'(SLOW_XT_LP_START_CYC);
  assign target[3] = CNT_W'(SLOW_RC_START_CYC);

  // One start-up timer per oscillator.
  for (genvar i = 0; i < 4; i++) begin : g_tmr
    osc_startup_timer #(
      .W(CNT_W)
    ) u_tmr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(osc_en_o[i]),
      .target_i(target[i]),
      .stable_o(stable[i])
    );
  end

  osc_clk_switch u_sw (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sw(sw_if.sw)
  );

  // Mode is frozen while the slow crystal is, or is about to be, the
  // system clock.
  assign sxt_locked = (req_src == `SRC_SLOW_XT) |
                      (sw_if.active == `SRC_SLOW_XT);

  //////////////////////////////////////////////////////////////////////
  // Wishbone slave and registers.

  assign word_adr = {wb_adr_i[7:2], 2'h0};
  assign wb_req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master sees ack.
  assign wb_wr = wb_req & wb_we_i & r_reg.ack & wb_sel_i[0];

  // Read mux; unmapped words read zero.
  always_comb begin
    rd_mux = 8'h00;
    unique case (word_adr)
      `ADR_SYS_CLK_CTRL: begin
        rd_mux[`DIV_HI:`DIV_LO] = r_reg.div;
        rd_mux[`HSEL_BIT] = r_reg.hsel;
        rd_mux[`LSEL_BIT] = r_reg.lsel;
        rd_mux[`FIDLE_BIT] = r_reg.fidle;
        rd_mux[`SIDLE_BIT] = r_reg.sidle;
      end
      `ADR_FAST_RC_CTRL: begin
        rd_mux[`FREQ_HI:`FREQ_LO] = r_reg.frc_freq;
        rd_mux[`STABLE_BIT] = stable[0];
        rd_mux[`EN_BIT] = r_reg.frc_en;
      end
      `ADR_FAST_XT_CTRL: begin
        rd_mux[`STABLE_BIT] = stable[1];
        rd_mux[`EN_BIT] = r_reg.fxt_en;
      end
      `ADR_SLOW_XT_CTRL: begin
        rd_mux[`SPEEDUP_BIT] = r_reg.sxt_sp;
        rd_mux[`STABLE_BIT] = stable[2];
        rd_mux[`EN_BIT] = r_reg.sxt_en;
      end
      `ADR_SW_STATUS: begin
        rd_mux[`BUSY_BIT] = sw_if.busy;
        rd_mux[1:0] = sw_if.active;
        rd_mux[3] = stable[3];
      end
      `ADR_PIN_SHARE: begin
        rd_mux[`EN_BIT] = r_reg.pin_osc;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // Register updates and bus handshake.
  always_comb begin
    r_next = r_reg;
    r_next.ack = wb_req & ~r_reg.ack;
    if (wb_req & ~r_reg.ack) begin
      r_next.rdata = rd_mux;
    end
    if (wb_wr) begin
      unique case (word_adr)
        `ADR_SYS_CLK_CTRL: begin
          r_next.div = wb_dat_i[`DIV_HI:`DIV_LO];
          r_next.hsel = wb_dat_i[`HSEL_BIT];
          r_next.lsel = wb_dat_i[`LSEL_BIT];
          r_next.fidle = wb_dat_i[`FIDLE_BIT];
          r_next.sidle = wb_dat_i[`SIDLE_BIT];
        end
        `ADR_FAST_RC_CTRL: begin
          r_next.frc_freq = wb_dat_i[`FREQ_HI:`FREQ_LO];
          r_next.frc_en = wb_dat_i[`EN_BIT];
        end
        `ADR_FAST_XT_CTRL: begin
          r_next.fxt_en = wb_dat_i[`EN_BIT];
        end
        `ADR_SLOW_XT_CTRL: begin
          r_next.sxt_en = wb_dat_i[`EN_BIT];
          if (!sxt_locked) begin
            r_next.sxt_sp = wb_dat_i[`SPEEDUP_BIT];
          end
        end
        `ADR_PIN_SHARE: begin
          r_next.pin_osc = wb_dat_i[`EN_BIT];
        end
        default: begin
          // Unmapped words drop the write; ack still stands one cycle.
        end
      endcase
    end
  end

  // Register state; the fast RC runs from reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.div <= `RST_DIV;
      r_reg.frc_freq <= `RST_FREQ;
      r_reg.frc_en <= `RST_FRC_EN;
      r_reg.sxt_sp <= `RST_SPEEDUP;
    end else begin
      r_reg <= r_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs.

  assign wb_ack_o = r_reg.ack;
  assign wb_dat_o = {24'h000000, r_reg.rdata};
  assign fast_rc_freq_o = r_reg.frc_freq;
  assign slow_crystal_speedup_o = r_reg.sxt_sp;
  assign slow_crystal_pins_osc_o = r_reg.pin_osc;
  assign sys_src_o = sw_if.active;
  assign clk_div_sel_o = r_reg.div;
  // Halt stops the core clock; the idle bits keep peripheral clocks.
  assign sys_clk_gate_o = sw_if.gate & ~halt_i;
  assign fast_periph_en_o = ~halt_i | r_reg.fidle;
  assign sub_clk_en_o = ~halt_i | r_reg.sidle;

  //////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_active_stable;
    sw_if.gate |-> stable[sw_if.active];
  endproperty
  a_active_stable: assert property (p_active_stable)
    else $error("gate open on an unstable source");

  property p_switch_gap;
    $changed(sw_if.active) |-> !sw_if.gate && !$past(sw_if.gate);
  endproperty
  a_switch_gap: assert property (p_switch_gap)
    else $error("source changed with the gate open");

  property p_fast_xt;
    (r_reg.div != `DIV_SLOW && r_reg.hsel && stable[1]) [*4]
      |-> sw_if.active == `SRC_FAST_XT;
  endproperty
  a_fast_xt: assert property (p_fast_xt)
    else $error("fast crystal not taken");

  property p_slow_xt;
    (r_reg.div == `DIV_SLOW && r_reg.lsel && stable[2]) [*4]
      |-> sw_if.active == `SRC_SLOW_XT;
  endproperty
  a_slow_xt: assert property (p_slow_xt)
    else $error("slow crystal not taken");

  property p_slow_rc;
    (r_reg.div == `DIV_SLOW && !r_reg.lsel && stable[3]) [*4]
      |-> sw_if.active == `SRC_SLOW_RC;
  endproperty
  a_slow_rc: assert property (p_slow_rc)
    else $error("slow RC not taken");

  property p_freq_write;
    (wb_wr && word_adr == `ADR_FAST_RC_CTRL)
      |=> fast_rc_freq_o == $past(wb_dat_i[`FREQ_HI:`FREQ_LO]);
  endproperty
  a_freq_write: assert property (p_freq_write)
    else $error("fast RC code not stored");

  property p_mode_lock;
    (wb_wr && word_adr == `ADR_SLOW_XT_CTRL && sxt_locked)
      |=> $stable(slow_crystal_speedup_o);
  endproperty
  a_mode_lock: assert property (p_mode_lock)
    else $error("slow crystal mode changed while selected");

  property p_keep_running;
    ($fell(slow_crystal_speedup_o) && stable[2] && osc_en_o[2])
      |-> stable[2] ##1 stable[2];
  endproperty
  a_keep_running: assert property (p_keep_running)
    else $error("slow crystal dropped on mode change");

  property p_halt;
    halt_i |-> !sys_clk_gate_o && osc_en_o[3];
  endproperty
  a_halt: assert property (p_halt)
    else $error("clock not stopped on halt");

  property p_stable_after_en;
    $rose(stable[2]) |-> $past(osc_en_o[2]) && $past(osc_en_o[2], 2);
  endproperty
  a_stable_after_en: assert property (p_stable_after_en)
    else $error("slow crystal stable without start-up");

  c_to_fast_xt: cover property ($rose(sw_if.active == `SRC_FAST_XT));
  c_sxt_stable: cover property ($rose(stable[2]));
  c_halt: cover property ($rose(halt_i) && sw_if.gate);
endmodule : osc_source_select

// ---- tb/osc_partner.sv ----
// Behavioural oscillators that settle a while after they are enabled.
`timescale 1ns/1ps
module osc_partner #(
  parameter int unsigned FXT_CYC = 20,
  parameter int unsigned SP_CYC = 30,
  parameter int unsigned LP_CYC = 60
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic [3:0] osc_en_i, // Enables from the selector.
  input wire logic speedup_i, // Slow crystal mode, 1 speed-up.
  output logic [3:0] run_o // Oscillator is up and settled.
);
  int unsigned cnt [4];
  int unsigned lim [4];
  logic [3:0] run_reg;
  // Start-up spans; the slow crystal is slower in low power mode.
  always_comb begin
    lim[0] = 400;
    lim[1] = FXT_CYC;
    lim[2] = speedup_i ? SP_CYC : LP_CYC;
    lim[3] = 2500;
  end
  // A settled oscillator keeps running until its enable drops, so a later
  // move to low power mode does not stop it.
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (rst_i || !osc_en_i[i]) begin
        cnt[i] <= 0;
        run_reg[i] <= 1'b0;
      end else begin
        cnt[i] <= cnt[i] + 1;
        if (cnt[i] >= lim[i]) begin
          run_reg[i] <= 1'b1;
        end
      end
    end
  end
  assign run_o = run_reg;
endmodule : osc_partner

// ---- tb/tb.sv ----
// Register-level bench for the oscillator source selector.
`timescale 1ns/1ps
`include "osc_consts.svh"
module tb;
  logic clk_i, rst_i, wb_we, wb_cyc, wb_stb, wb_ack, halt;
  logic [7:0] wb_adr;
  logic [31:0] wb_wdat, wb_rdat;
  logic [3:0] wb_sel, osc_en, osc_run;
  logic [1:0] rc_freq, sys_src;
  logic [2:0] div_sel;
  logic speedup, pins_osc, gate, fast_pe, sub_pe;
  logic [31:0] q;
  int num_errors = 0;
  int checked = 0;
  // Short start-up spans; the partner's defaults use the same ones.
  osc_source_select #(.FAST_XT_START_CYC(20), .SLOW_XT_SP_START_CYC(30),
    .SLOW_XT_LP_START_CYC(60)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_ack_o(wb_ack), .halt_i(halt),
    .osc_en_o(osc_en), .fast_rc_freq_o(rc_freq),
    .slow_crystal_speedup_o(speedup), .slow_crystal_pins_osc_o(pins_osc),
    .sys_src_o(sys_src), .sys_clk_gate_o(gate), .clk_div_sel_o(div_sel),
    .fast_periph_en_o(fast_pe), .sub_clk_en_o(sub_pe));
  osc_partner osc (
    .clk_i(clk_i), .rst_i(rst_i), .osc_en_i(osc_en),
    .speedup_i(speedup), .run_o(osc_run));
  //////////////////////////////////////////////////////////////////////////
  // Compare, count and report a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One classic Wishbone cycle; held until ack is sampled high.
  task automatic xfer(input logic [7:0] a, input logic w,
      input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    wb_adr <= a;
    wb_we <= w;
    wb_wdat <= 32'(d);
    wb_sel <= s;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 100);
    if (n >= 100) chk("ack", 32'h1, 32'h0);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d, 4'hf);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00, 4'hf);
    chk($sformatf("reg %h", a), 32'(e), q);
  endtask : rd
  // Waiting is bounded; the switch may hold off until a source settles.
  task automatic wait_src(input logic [1:0] e, input int lim);
    int n;
    n = 0;
    while (sys_src !== e && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk("sys_src", 32'(e), 32'(sys_src));
  endtask : wait_src
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  //////////////////////////////////////////////////////////////////////////
  // Free-running 25 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // The whole run needs under 5000 cycles; this is generous headroom.
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    print_verdict();
  end
  // Test sequence.
  initial begin
    {rst_i, wb_we, wb_cyc, wb_stb, halt} = 5'b10000;
    {wb_adr, wb_wdat, wb_sel} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("osc_en", 32'h9, 32'(osc_en));
    chk("gate", 32'h0, 32'(gate));
    rd(`ADR_FAST_RC_CTRL, {6'h0, osc_run[0], 1'b1});
    rd(`ADR_SYS_CLK_CTRL, 8'h00);
    rd(`ADR_FAST_XT_CTRL, 8'h00);
    rd(`ADR_SLOW_XT_CTRL, 8'h04);
    rd(`ADR_PIN_SHARE, 8'h00);
    wr(8'h18, 8'hff);
    rd(8'h18, 8'h00);
    repeat (420) @(posedge clk_i);
    rd(`ADR_FAST_RC_CTRL, 8'h03);
    chk("gate", 32'h1, 32'(gate));
    $display("test reset done");
    // Only codes that match a configured frequency are programmed.
    for (int i = 0; i < 3; i++) begin
      wr(`ADR_FAST_RC_CTRL, {4'h0, 2'(i), 2'h1});
      chk("rc_freq", 32'(i), 32'(rc_freq));
      rd(`ADR_FAST_RC_CTRL, {4'h0, 2'(i), 2'h3});
    end
    xfer(`ADR_FAST_RC_CTRL, 1'b1, 8'h01, 4'he);
    chk("rc_freq", 32'h2, 32'(rc_freq));
    $display("test fast rc done");
    wr(`ADR_FAST_XT_CTRL, 8'h01);
    wr(`ADR_SYS_CLK_CTRL, 8'h08);
    chk("sys_src", 32'h0, 32'(sys_src));
    wait_src(2'h1, 60);
    chk("osc_en", 32'hb, 32'(osc_en));
    rd(`ADR_FAST_XT_CTRL, {6'h0, osc_run[1], 1'b1});
    rd(`ADR_SW_STATUS, {4'h0, osc_run[3], 3'h1});
    for (int d = 0; d < 7; d++) begin
      wr(`ADR_SYS_CLK_CTRL, {3'(d), 5'h08});
      chk("div", 32'(d), 32'(div_sel));
      chk("sys_src", 32'h1, 32'(sys_src));
    end
    $display("test fast crystal done");
    // Halted: the idle bits decide which peripheral clocks survive.
    wr(`ADR_SYS_CLK_CTRL, 8'h0a);
    halt <= 1'b1;
    @(posedge clk_i);
    chk("gate", 32'h0, 32'(gate));
    chk("fast_pe", 32'h1, 32'(fast_pe));
    chk("sub_pe", 32'h0, 32'(sub_pe));
    wr(`ADR_SYS_CLK_CTRL, 8'h09);
    chk("fast_pe", 32'h0, 32'(fast_pe));
    chk("sub_pe", 32'h1, 32'(sub_pe));
    halt <= 1'b0;
    @(posedge clk_i);
    chk("gate", 32'h1, 32'(gate));
    $display("test halt done");
    wr(`ADR_SLOW_XT_CTRL, 8'h05);
    chk("osc_en", 32'hf, 32'(osc_en));
    repeat (10) @(posedge clk_i);
    rd(`ADR_SLOW_XT_CTRL, {5'h1, osc_run[2], 1'b1});
    repeat (30) @(posedge clk_i);
    rd(`ADR_SLOW_XT_CTRL, {5'h1, osc_run[2], 1'b1});
    wr(`ADR_SLOW_XT_CTRL, 8'h01);
    chk("speedup", 32'h0, 32'(speedup));
    rd(`ADR_SLOW_XT_CTRL, 8'h03);
    wr(`ADR_SLOW_XT_CTRL, 8'h00);
    wr(`ADR_SLOW_XT_CTRL, 8'h01);
    repeat (40) @(posedge clk_i);
    rd(`ADR_SLOW_XT_CTRL, {6'h0, osc_run[2], 1'b1});
    repeat (25) @(posedge clk_i);
    rd(`ADR_SLOW_XT_CTRL, {6'h0, osc_run[2], 1'b1});
    wr(`ADR_SYS_CLK_CTRL, 8'he4);
    wait_src(2'h2, 20);
    wr(`ADR_SLOW_XT_CTRL, 8'h05);
    chk("speedup", 32'h0, 32'(speedup));
    $display("test slow crystal done");
    wr(`ADR_PIN_SHARE, 8'h01);
    chk("pins", 32'h1, 32'(pins_osc));
    rd(`ADR_PIN_SHARE, 8'h01);
    wr(`ADR_PIN_SHARE, 8'h00);
    chk("pins", 32'h0, 32'(pins_osc));
    wr(`ADR_SYS_CLK_CTRL, 8'he0);
    wait_src(2'h3, 3000);
    rd(`ADR_SW_STATUS, {4'h0, osc_run[3], 3'h3});
    wr(`ADR_SLOW_XT_CTRL, 8'h05);
    chk("speedup", 32'h1, 32'(speedup));
    $display("test slow rc done");
    // An unsettled source is refused; the clock stays where it is.
    wr(`ADR_FAST_XT_CTRL, 8'h00);
    chk("osc_en", 32'hd, 32'(osc_en));
    wr(`ADR_SYS_CLK_CTRL, 8'h08);
    repeat (30) @(posedge clk_i);
    chk("sys_src", 32'h3, 32'(sys_src));
    wr(`ADR_SYS_CLK_CTRL, 8'h00);
    wait_src(2'h0, 20);
    $display("test refusal done");
    print_verdict();
  end
endmodule : tb
